// ===== axi_lite_to_reg_bridge.sv
// AXI4-Lite slave bridged to a word-indexed register port in a second clock domain
// Notes on behaviour
// RULE1: Host transfers become register transfers with one 32-bit write and read word.
// RULE2: Host side on clk, register port on logic_side_clock, joined by toggle crossings.
// RULE3: A write pulses reg_write_strobe with index, word and lane mask valid.
// RULE4: reg_word_index counts 32-bit words, not bytes, for writes and reads.
// RULE5: Four-bit lane mask; bit n qualifies byte n of the write word.
// RULE6: A read raises reg_read_request together with a valid word index.
// RULE7: Register logic starts a read on request and answers with return valid.
// RULE8: Register logic returns one full 32-bit word for each read.
// RULE9: Word index holds from request until return valid is seen.
// RULE10: Write and read never happen together on the register port.
// RULE11: Register logic makes return valid from request through two flip-flops; reg_file_model uses four in slow mode.
// RULE12: Read response goes out only after data and valid cross back.
`timescale 1ns/1ps
`include "bridge_params.svh"

module axi_lite_to_reg_bridge #(
	parameter int ADDR_W = `BR_ADDR_W,
	parameter int IDX_W  = ADDR_W - `BR_WORD_LSB
) (
	// Host side clock and reset
	input  wire logic                   clk,
	input  wire logic                   resetn,
	// Write address channel
	input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output var  logic                   s_axi_awready,
	// Write data channel
	input  wire logic [`BR_DATA_W-1:0]  s_axi_wdata,
	input  wire logic [`BR_LANE_W-1:0]  s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output var  logic                   s_axi_wready,
	// Write response channel
	output var  logic [1:0]             s_axi_bresp,
	output var  logic                   s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// Read address channel
	input  wire logic [ADDR_W-1:0]      s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output var  logic                   s_axi_arready,
	// Read data channel
	output var  logic [`BR_DATA_W-1:0]  s_axi_rdata,
	output var  logic [1:0]             s_axi_rresp,
	output var  logic                   s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Register port, on its own clock
	input  wire logic                   logic_side_clock,
	output var  logic                   reg_write_strobe,
	output var  logic                   reg_read_request,
	output var  logic [IDX_W-1:0]       reg_word_index,
	output var  logic [`BR_DATA_W-1:0]  reg_write_word,
	output var  logic [`BR_LANE_W-1:0]  reg_lane_mask,
	input  wire logic                   reg_read_return_valid,
	input  wire logic [`BR_DATA_W-1:0]  reg_read_word
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	reg_xfer_if #(.IDX_W(IDX_W)) xfer ();

	bridge_pkg::host_state_e  state_r;
	logic                     respRead_r;
	logic                     cmdToggle_r;
	logic                     cmdRead_r;
	logic [IDX_W-1:0]         cmdIndex_r;
	logic [`BR_DATA_W-1:0]    cmdData_r;
	logic [`BR_LANE_W-1:0]    cmdMask_r;
	logic [2:0]               ackSync_r;
	logic                     ackSeen_r;
	logic [`BR_DATA_W-1:0]    rdata_r;
	logic                     takeWrite;
	logic                     takeRead;
	logic                     ackEvent;

	// Byte address to word index
	function automatic logic [IDX_W-1:0] wordIndex(input logic [ADDR_W-1:0] byteAddr);
		wordIndex = byteAddr[ADDR_W-1:`BR_WORD_LSB];
	endfunction : wordIndex

	// ------------------------------------------------------------
	// Host handshakes
	// ------------------------------------------------------------
	// Writes win a tie; address and data are taken together, so a lone
	// write address waits until its data shows up
	assign takeWrite = (state_r == bridge_pkg::HOST_IDLE) && s_axi_awvalid && s_axi_wvalid;
	assign takeRead  = (state_r == bridge_pkg::HOST_IDLE) && !takeWrite && s_axi_arvalid;

	assign s_axi_awready = takeWrite;
	assign s_axi_wready  = takeWrite;
	assign s_axi_arready = takeRead;

	// Responses are always OKAY; every word index is passed on
	assign s_axi_bresp  = `BR_RESP_OKAY;
	assign s_axi_rresp  = `BR_RESP_OKAY;
	assign s_axi_bvalid = (state_r == bridge_pkg::HOST_RESP) && !respRead_r;
	assign s_axi_rvalid = (state_r == bridge_pkg::HOST_RESP) && respRead_r;
	assign s_axi_rdata  = rdata_r;

	// ------------------------------------------------------------
	// Host sequencing
	// ------------------------------------------------------------
	// One transfer in flight; the next is taken only after the response
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r <= bridge_pkg::HOST_IDLE;
		end else begin
			case (state_r)
				bridge_pkg::HOST_IDLE: begin
					if (takeWrite || takeRead) begin
						state_r <= bridge_pkg::HOST_WAIT;
					end
				end
				bridge_pkg::HOST_WAIT: begin
					if (ackEvent) begin
						state_r <= bridge_pkg::HOST_RESP;  // [RULE12]
					end
				end
				bridge_pkg::HOST_RESP: begin
					if (respRead_r ? s_axi_rready : s_axi_bready) begin
						state_r <= bridge_pkg::HOST_IDLE;
					end
				end
				default: begin
					state_r <= bridge_pkg::HOST_IDLE;
				end
			endcase
		end
	end

	// Command fields; they stay steady until the answer crosses back
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cmdToggle_r <= 1'h0;
			cmdRead_r   <= 1'h0;
			cmdIndex_r  <= '0;
			cmdData_r   <= `BR_WORD_RST;
			cmdMask_r   <= `BR_MASK_RST;
			respRead_r  <= 1'h0;
		end else if (takeWrite) begin
			cmdToggle_r <= ~cmdToggle_r;               // [RULE2]
			cmdRead_r   <= 1'h0;
			cmdIndex_r  <= wordIndex(s_axi_awaddr);    // [RULE4]
			cmdData_r   <= s_axi_wdata;                // [RULE1]
			cmdMask_r   <= s_axi_wstrb;                // [RULE5]
			respRead_r  <= 1'h0;
		end else if (takeRead) begin
			cmdToggle_r <= ~cmdToggle_r;               // [RULE2]
			cmdRead_r   <= 1'h1;
			cmdIndex_r  <= wordIndex(s_axi_araddr);    // [RULE4]
			respRead_r  <= 1'h1;
		end
	end

	// ------------------------------------------------------------
	// Answer crossing
	// ------------------------------------------------------------
	// Three stages; the answer counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ackSync_r <= `BR_SYNC_RST;
			ackSeen_r <= 1'h0;
		end else begin
			ackSync_r <= {ackSync_r[1:0], xfer.ackToggle};  // [RULE2]
			if (ackSync_r[1] == ackSync_r[2]) begin
				ackSeen_r <= ackSync_r[2];
			end
		end
	end

	assign ackEvent = (ackSync_r[1] == ackSync_r[2]) && (ackSync_r[2] != ackSeen_r);

	// Read word was loaded on the same edge its toggle flipped and held while it crossed, so it is safe here
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_r <= `BR_WORD_RST;
		end else if ((state_r == bridge_pkg::HOST_WAIT) && ackEvent && respRead_r) begin
			rdata_r <= xfer.ackData;  // [RULE12] [RULE1]
		end
	end

	// ------------------------------------------------------------
	// Crossing bundle and logic-side engine
	// ------------------------------------------------------------
	assign xfer.cmdToggle = cmdToggle_r;
	assign xfer.cmdRead   = cmdRead_r;
	assign xfer.cmdIndex  = cmdIndex_r;
	assign xfer.cmdData   = cmdData_r;
	assign xfer.cmdMask   = cmdMask_r;

	reg_port_engine #(
		.IDX_W (IDX_W)
	) u_engine (
		.logic_side_clock      (logic_side_clock),
		.resetn                (resetn),
		.xfer                  (xfer.logicEnd),
		.reg_write_strobe      (reg_write_strobe),
		.reg_read_request      (reg_read_request),
		.reg_word_index        (reg_word_index),
		.reg_write_word        (reg_write_word),
		.reg_lane_mask         (reg_lane_mask),
		.reg_read_return_valid (reg_read_return_valid),
		.reg_read_word         (reg_read_word)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	index_capture_a: assert property (@(posedge clk) disable iff (!resetn)
		takeWrite |=> (cmdIndex_r == $past(s_axi_awaddr[ADDR_W-1:`BR_WORD_LSB])
			&& !cmdRead_r)) else $error("write index not in words"); // [RULE4]
	toggle_on_take_a: assert property (@(posedge clk) disable iff (!resetn)
		$changed(cmdToggle_r) |-> $past(takeWrite || takeRead))
		else $error("command toggle without host transfer"); // [RULE2]
	resp_after_ack_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(s_axi_rvalid) |-> ($past(ackEvent) && s_axi_rdata == xfer.ackData))
		else $error("read answered before crossing"); // [RULE12]
	single_flight_a: assert property (@(posedge clk) disable iff (!resetn)
		(takeWrite || takeRead) |=> (state_r == bridge_pkg::HOST_WAIT) ##1
			(!s_axi_awready && !s_axi_arready)) else $error("second transfer taken"); // [RULE10]

endmodule : axi_lite_to_reg_bridge

// ===== bridge_params.svh
// Shared constants of the host-to-register bridge
`ifndef BRIDGE_PARAMS_SVH
`define BRIDGE_PARAMS_SVH

// ----------------------------------------------------------------
// Data path
// ----------------------------------------------------------------
`define BR_DATA_W     32
`define BR_LANE_W     4
`define BR_WORD_LSB   2
`define BR_ADDR_W     20

// ----------------------------------------------------------------
// Host answers and reset values
// ----------------------------------------------------------------
`define BR_RESP_OKAY  2'h0
`define BR_SYNC_RST   3'h0
`define BR_WORD_RST   32'h0000_0000
`define BR_MASK_RST   4'h0

`endif

// ===== bridge_pkg.sv
// Types shared by the host-to-register bridge modules
package bridge_pkg;

	// ------------------------------------------------------------
	// State machines
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		HOST_IDLE = 2'b00,
		HOST_WAIT = 2'b01,
		HOST_RESP = 2'b10
	} host_state_e;

	typedef enum logic {
		PORT_IDLE = 1'b0,
		PORT_READ = 1'b1
	} port_state_e;

endpackage : bridge_pkg

// ===== reg_xfer_if.sv
// Command and answer bundle crossing between the two clock domains
`timescale 1ns/1ps
`include "bridge_params.svh"

interface reg_xfer_if #(
	parameter int IDX_W = `BR_ADDR_W - `BR_WORD_LSB
);
	// Host domain to logic domain, steady while a command is open
	logic                   cmdToggle;
	logic                   cmdRead;
	logic [IDX_W-1:0]       cmdIndex;
	logic [`BR_DATA_W-1:0]  cmdData;
	logic [`BR_LANE_W-1:0]  cmdMask;
	// Logic domain to host domain
	logic                   ackToggle;
	logic [`BR_DATA_W-1:0]  ackData;

	modport hostEnd (
		output cmdToggle, cmdRead, cmdIndex, cmdData, cmdMask,
		input  ackToggle, ackData
	);
	modport logicEnd (
		input  cmdToggle, cmdRead, cmdIndex, cmdData, cmdMask,
		output ackToggle, ackData
	);
endinterface : reg_xfer_if

// ===== reg_port_engine.sv
// Logic-side driver of the register port
`timescale 1ns/1ps
`include "bridge_params.svh"

module reg_port_engine #(
	parameter int IDX_W = `BR_ADDR_W - `BR_WORD_LSB
) (
	// Logic-side clock and the host-domain reset
	input  wire logic                   logic_side_clock,
	input  wire logic                   resetn,
	// Crossing bundle
	reg_xfer_if.logicEnd                xfer,
	// Register port
	output var  logic                   reg_write_strobe,
	output var  logic                   reg_read_request,
	output var  logic [IDX_W-1:0]       reg_word_index,
	output var  logic [`BR_DATA_W-1:0]  reg_write_word,
	output var  logic [`BR_LANE_W-1:0]  reg_lane_mask,
	input  wire logic                   reg_read_return_valid,
	input  wire logic [`BR_DATA_W-1:0]  reg_read_word
);
	bridge_pkg::port_state_e  state_r;
	logic [2:0]               rstSync_r;
	logic                     portResetn_r;
	logic [2:0]               cmdSync_r;
	logic                     cmdSeen_r;
	logic                     ackToggle_r;
	logic [`BR_DATA_W-1:0]    ackData_r;
	logic                     cmdEvent;

	// ------------------------------------------------------------
	// Reset and command crossing
	// ------------------------------------------------------------
	// Reset arrives from the host domain; a change counts once stages agree
	always_ff @(posedge logic_side_clock) begin
		rstSync_r <= {rstSync_r[1:0], resetn};
		if (rstSync_r[1] == rstSync_r[2]) begin
			portResetn_r <= rstSync_r[2];
		end
	end

	// Command toggle: three stages, counted once stages two and three agree
	always_ff @(posedge logic_side_clock) begin
		if (!portResetn_r) begin
			cmdSync_r <= `BR_SYNC_RST;
			cmdSeen_r <= 1'h0;
		end else begin
			cmdSync_r <= {cmdSync_r[1:0], xfer.cmdToggle};
			if (cmdSync_r[1] == cmdSync_r[2]) begin
				cmdSeen_r <= cmdSync_r[2];
			end
		end
	end

	assign cmdEvent = (cmdSync_r[1] == cmdSync_r[2]) && (cmdSync_r[2] != cmdSeen_r);

	// ------------------------------------------------------------
	// Register port sequencing
	// ------------------------------------------------------------
	// Only one transfer is open at a time, so writes and reads never meet
	always_ff @(posedge logic_side_clock) begin
		if (!portResetn_r) begin
			state_r <= bridge_pkg::PORT_IDLE;
		end else begin
			case (state_r)
				bridge_pkg::PORT_IDLE: begin
					if (cmdEvent && xfer.cmdRead) begin
						state_r <= bridge_pkg::PORT_READ;
					end
				end
				bridge_pkg::PORT_READ: begin
					if (reg_read_return_valid) begin
						state_r <= bridge_pkg::PORT_IDLE;
					end
				end
				default: begin
					state_r <= bridge_pkg::PORT_IDLE;
				end
			endcase
		end
	end

	// One-cycle strobe or request when a command lands
	always_ff @(posedge logic_side_clock) begin
		if (!portResetn_r) begin
			reg_write_strobe <= 1'h0;
			reg_read_request <= 1'h0;
		end else begin
			reg_write_strobe <= (state_r == bridge_pkg::PORT_IDLE) && cmdEvent
				&& !xfer.cmdRead;  // [RULE3] [RULE10]
			reg_read_request <= (state_r == bridge_pkg::PORT_IDLE) && cmdEvent
				&& xfer.cmdRead;   // [RULE6] [RULE10]
		end
	end

	// Fields load only in idle, so the index holds through a read
	always_ff @(posedge logic_side_clock) begin
		if (!portResetn_r) begin
			reg_word_index <= '0;
			reg_write_word <= `BR_WORD_RST;
			reg_lane_mask  <= `BR_MASK_RST;
		end else if ((state_r == bridge_pkg::PORT_IDLE) && cmdEvent) begin
			reg_word_index <= xfer.cmdIndex;  // [RULE4] [RULE9]
			reg_write_word <= xfer.cmdData;   // [RULE1]
			reg_lane_mask  <= xfer.cmdMask;   // [RULE5]
		end
	end

	// Answer: read data loads on the same edge as the toggle and holds while it crosses, so the host sees it steady; a write answer flips the toggle alone
	always_ff @(posedge logic_side_clock) begin
		if (!portResetn_r) begin
			ackToggle_r <= 1'h0;
			ackData_r   <= `BR_WORD_RST;
		end else if ((state_r == bridge_pkg::PORT_IDLE) && cmdEvent && !xfer.cmdRead) begin
			ackToggle_r <= ~ackToggle_r;
		end else if ((state_r == bridge_pkg::PORT_READ) && reg_read_return_valid) begin
			ackToggle_r <= ~ackToggle_r;
			ackData_r   <= reg_read_word;  // [RULE1]
		end
	end

	assign xfer.ackToggle = ackToggle_r;
	assign xfer.ackData   = ackData_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	strobe_one_cycle_a: assert property (@(posedge logic_side_clock) disable iff (!portResetn_r)
		reg_write_strobe |=> !reg_write_strobe) else $error("write strobe held too long"); // [RULE3]
	no_rw_overlap_a: assert property (@(posedge logic_side_clock) disable iff (!portResetn_r)
		reg_write_strobe |-> (!reg_read_request && state_r == bridge_pkg::PORT_IDLE))
		else $error("write during read"); // [RULE10]
	index_hold_a: assert property (@(posedge logic_side_clock) disable iff (!portResetn_r)
		(state_r == bridge_pkg::PORT_READ && !reg_read_return_valid) |=> $stable(reg_word_index))
		else $error("index moved during read"); // [RULE9]
	write_fields_a: assert property (@(posedge logic_side_clock) disable iff (!portResetn_r)
		reg_write_strobe |-> (reg_lane_mask == xfer.cmdMask && reg_write_word == xfer.cmdData))
		else $error("write fields differ from command"); // [RULE5]
	request_pulse_a: assert property (@(posedge logic_side_clock) disable iff (!portResetn_r)
		reg_read_request |-> ##1 (!reg_read_request && reg_word_index == $past(reg_word_index)))
		else $error("read request not a single pulse"); // [RULE6]

endmodule : reg_port_engine

// ===== reg_file_model.sv
// Register file stand-in that sits on the logic side of the bridge
`timescale 1ns/1ps
`include "bridge_params.svh"

module reg_file_model #(
	parameter int IDX_W = 18
) (
	// Clock and answer speed
	input  wire logic                   clk,
	input  wire logic                   slowMode,
	// Register port
	input  wire logic                   reg_write_strobe,
	input  wire logic                   reg_read_request,
	input  wire logic [IDX_W-1:0]       reg_word_index,
	input  wire logic [`BR_DATA_W-1:0]  reg_write_word,
	input  wire logic [`BR_LANE_W-1:0]  reg_lane_mask,
	output var  logic                   reg_read_return_valid,
	output var  logic [`BR_DATA_W-1:0]  reg_read_word
);
	logic [`BR_DATA_W-1:0] mem [16];
	logic [3:0]            delay_r = 4'h0;

	// Only lanes with their mask bit set change
	always @(posedge clk) begin
		for (int n = 0; n < 4; n++) begin
			if (reg_write_strobe && reg_lane_mask[n]) begin
				mem[reg_word_index[3:0]][8*n +: 8] <= reg_write_word[8*n +: 8];
			end
		end
	end

	// Request delayed through flops; slow mode adds two more to stress the hold
	always @(posedge clk) begin
		delay_r <= {delay_r[2:0], reg_read_request};
	end
	assign reg_read_return_valid = slowMode ? delay_r[3] : delay_r[1];

	// Whole word on valid; otherwise inverted so stale data cannot pass
	assign reg_read_word = reg_read_return_valid ? mem[reg_word_index[3:0]]
		: ~mem[reg_word_index[3:0]];
endmodule : reg_file_model

// ===== axi_lite_to_reg_cdc_bridge_bench.sv
// Self-checking bench of the host-to-register bridge
`timescale 1ns/1ps

module axi_lite_to_reg_cdc_bridge_bench;
	logic        clk = 1'h0, lclk = 1'h0, resetn = 1'h0, slowMode = 1'h0;
	logic [19:0] awaddr = 20'h0, araddr = 20'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic        arvalid = 1'h0, rready = 1'h0, pending = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, wrStrobe, rdReq, rdValid;
	logic [1:0]  bresp, rresp, respSnap;
	logic [31:0] rdata, regWord, rdWord, seenWord, dataSnap;
	logic [17:0] wordIdx, heldIdx, seenIdx;
	logic [3:0]  laneMask, seenMask;
	int          error_cnt = 0, check_count = 0, strobeCnt = 0;

	// Host clock 5 ns; logic clock 7 ns so the phases drift
	always #2.5 clk = ~clk;
	always #3.5 lclk = ~lclk;

	axi_lite_to_reg_bridge u_dut (.clk(clk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .logic_side_clock(lclk),
		.reg_write_strobe(wrStrobe), .reg_read_request(rdReq),
		.reg_word_index(wordIdx), .reg_write_word(regWord), .reg_lane_mask(laneMask),
		.reg_read_return_valid(rdValid), .reg_read_word(rdWord));

	reg_file_model u_regs (.clk(lclk), .slowMode(slowMode),
		.reg_write_strobe(wrStrobe), .reg_read_request(rdReq),
		.reg_word_index(wordIdx), .reg_write_word(regWord), .reg_lane_mask(laneMask),
		.reg_read_return_valid(rdValid), .reg_read_word(rdWord));

	task automatic fail(input string msg);
		error_cnt++;
		$display("Error at %0t: %s", $time, msg);
	endtask : fail

	task automatic expect32(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) fail(what);
	endtask : expect32

	task automatic tally_and_finish();
		$display("Checks %0d, errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish

	// Bounded wait, judged at the falling edge where levels are settled;
	// returns just after the rising edge that completes the handshake
	task automatic wait_for(input int which, input string what);
		logic hit;
		for (int i = 0; i < 400; i++) begin
			@(negedge clk);
			hit = (which == 0) ? awready : (which == 1) ? bvalid
				: (which == 2) ? arready : rvalid;
			if (hit === 1'h1) begin
				respSnap = (which == 1) ? bresp : rresp;
				dataSnap = rdata;
				@(posedge clk);
				#1;
				return;
			end
		end
		fail(what);
		tally_and_finish();
	endtask : wait_for

	// Address and data channels of a write must be taken together
	always @(negedge clk) begin
		if (resetn && awready !== wready) fail("write channels taken apart");
	end

	// Register port monitor: captures writes, guards index hold and exclusivity
	always @(posedge lclk) begin
		if (wrStrobe === 1'h1 && rdReq === 1'h1) fail("write and read together");
		if (pending && wordIdx !== heldIdx) fail("index moved during read");
		if (rdReq === 1'h1) begin
			pending <= 1'h1;
			heldIdx <= wordIdx;
		end
		if (rdValid) pending <= 1'h0;
		if (wrStrobe === 1'h1) begin
			seenIdx  <= wordIdx;
			seenWord <= regWord;
			seenMask <= laneMask;
			strobeCnt++;
		end
	end

	// One host write, then the single strobe it caused is judged
	task automatic axi_write(input logic [19:0] a, input logic [31:0] d, input logic [3:0] m);
		int n0;
		n0 = strobeCnt;
		awaddr = a;
		wdata = d;
		wstrb = m;
		awvalid = 1'h1;
		wvalid = 1'h1;
		bready = 1'h1;
		wait_for(0, "write not taken");
		awvalid = 1'h0;
		wvalid = 1'h0;
		wait_for(1, "no write response");
		bready = 1'h0;
		expect32(respSnap, 32'h0, "write response code");
		expect32(strobeCnt - n0, 32'h1, "strobe count");
		expect32(seenIdx, a[19:2], "write word index");
		expect32(seenWord, d, "write word");
		expect32(seenMask, m, "lane mask");
	endtask : axi_write

	// One host read, checked against the expected word
	task automatic axi_read(input logic [19:0] a, input logic [31:0] exp);
		araddr = a;
		arvalid = 1'h1;
		rready = 1'h1;
		wait_for(2, "read not taken");
		arvalid = 1'h0;
		wait_for(3, "no read response");
		rready = 1'h0;
		expect32(pending, 32'h0, "response before return");
		expect32(heldIdx, a[19:2], "read word index");
		expect32(dataSnap, exp, "read data");
		expect32(respSnap, 32'h0, "read response code");
	endtask : axi_read

	// Full word round trip, byte address with low bits set
	task automatic sc_round_trip();
		axi_write(20'h00017, 32'ha5c3_1e78, 4'hf);
		axi_read(20'h00016, 32'ha5c3_1e78);
	endtask : sc_round_trip

	// Each lane alone, back to back; earlier lanes must survive
	task automatic sc_lanes();
		logic [31:0] exp;
		exp = 32'h0;
		axi_write(20'h00008, 32'h0, 4'hf);
		for (int n = 0; n < 4; n++) begin
			exp[8*n +: 8] = 8'hff;
			axi_write(20'h00008, 32'hffff_ffff, 4'h1 << n);
			axi_read(20'h00008, exp);
		end
	endtask : sc_lanes

	// Slow answer at the top index: index must hold for the whole wait
	task automatic sc_slow_top();
		slowMode = 1'h1;
		axi_write(20'hffffc, 32'h0f1e_2d3c, 4'hf);
		axi_read(20'hffffc, 32'h0f1e_2d3c);
		axi_read(20'h00016, 32'ha5c3_1e78);
		slowMode = 1'h0;
	endtask : sc_slow_top

	// Reset held long enough for both domains, then the scenarios
	initial begin
		repeat (8) @(posedge clk);
		#1;
		resetn = 1'h1;
		repeat (12) @(posedge clk);
		#1;
		expect32({bvalid, rvalid, awready, arready}, 32'h0, "idle after reset");
		sc_round_trip();
		sc_lanes();
		sc_slow_top();
		tally_and_finish();
	end
endmodule : axi_lite_to_reg_cdc_bridge_bench
